//--- include/fpl_pkg.sv
package fpl_pkg;
  localparam int          NUM_SECT       = 10;
  localparam int          NUM_PAIR       = 16;
  localparam logic [23:0] ADDR_WP_FUSES  = 24'h08dfb0;
  localparam logic [23:0] ADDR_AD_FUSES  = 24'h08dfb8;
  localparam logic [23:0] ADDR_DIS_FUSES = 24'h08dfbc;
  localparam logic [23:0] ADDR_EN_FUSES  = 24'h08dfbe;
  localparam logic [7:0]  OFS_TAU        = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h04;
  localparam logic [7:0]  OFS_WP_VOL     = 8'h08;
  localparam logic [7:0]  OFS_AD_VOL     = 8'h0c;
  localparam logic [7:0]  OFS_DIS_VOL    = 8'h10;
  localparam logic [7:0]  OFS_EN_VOL     = 8'h14;
  localparam logic [15:0] FUSE_ERASED    = 16'hffff;
  localparam logic [15:0] FUSE_ACTIVE    = 16'h0000;
  localparam int          BIT_ACCESS_PROTECT_FUSE       = 0;
  localparam int          BIT_DEBUG_PROTECT_FUSE       = 1;
  localparam int          BIT_TEMPORARY_UNPROTECT_BIT       = 0;
  localparam logic [15:0] TRAP_CODE      = 16'h009b;
  localparam logic [15:0] DUMMY_DATA     = 16'h0000;

  typedef enum logic [3:0] {
    FPL_ST_LOAD = 4'b0001,
    FPL_ST_RUN  = 4'b0010,
    FPL_ST_PROG = 4'b0100,
    FPL_ST_DONE = 4'b1000
  } fpl_state_type;

  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
    logic [15:0] data;
  } fpl_prog_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        from_flash;
    logic        from_pec;
  } fpl_access_type;
endpackage

//--- rtl/fpl_protect.sv
`timescale 1ns/10ps
module fpl_protect (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Fuse array interface.
  output logic                       fuse_rd_req,
  output logic [1:0]                 fuse_rd_idx,
  input  wire logic [15:0]           fuse_rd_data,
  output logic                       fuse_wr,
  output logic [1:0]                 fuse_wr_idx,
  output logic [15:0]                fuse_wr_data,
  // Set Protection request from the write sequencer.
  input  wire fpl_pkg::fpl_prog_type prog_req,
  input  wire logic                  prog_from_flash,
  output logic                       prog_done,
  output logic                       prog_refused,
  // Sector program or erase request.
  input  wire logic                  sect_req,
  input  wire logic [9:0]            sect_sel,
  output logic [9:0]                 sect_allow,
  output logic                       wp_error,
  // Data access to flash space and control registers.
  input  wire fpl_pkg::fpl_access_type data_acc,
  output logic                       data_allow,
  output logic                       data_dummy,
  output logic                       trap_req,
  output logic [15:0]                trap_code,
  input  wire fpl_pkg::fpl_access_type ctrl_acc,
  output logic                       ctrl_allow,
  // Debug gating.
  output logic                       debug_enable,
  output logic                       access_protected,
  // Register port.
  input  wire logic [7:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic                  reg_wr_from_flash,
  output logic [15:0]                reg_rdata
);
  import fpl_pkg::*;

  fpl_state_type state_reg;
  logic [1:0]    load_idx_reg;
  logic          load_wait_reg;
  logic [15:0]   wp_reg;
  logic [15:0]   ad_reg;
  logic [15:0]   dis_reg;
  logic [15:0]   en_reg;
  logic          temporary_unprotect_bit_reg;
  logic          wp_err_reg;
  logic          loaded;
  logic          access_protect_fuse_cancel;
  logic          prot_on;
  logic          prog_ok;
  logic [1:0]    prog_idx;
  logic [15:0]   prog_cur;

  assign loaded = (state_reg != FPL_ST_LOAD);

  // Fuse x pair: disable zero while enable still one cancels the fuse.
  always_comb begin
    access_protect_fuse_cancel = 1'b0;
    for (int i = 0; i < NUM_PAIR; i++) begin
      if (!dis_reg[i] && en_reg[i]) access_protect_fuse_cancel = 1'b1;
    end
  end

  assign prot_on = !loaded ||
                   (!ad_reg[BIT_ACCESS_PROTECT_FUSE] && !access_protect_fuse_cancel && !temporary_unprotect_bit_reg);

  function automatic logic [1:0] fuse_index(input logic [23:0] a);
    case (a)
      ADDR_WP_FUSES:  fuse_index = 2'd0;
      ADDR_AD_FUSES:  fuse_index = 2'd1;
      ADDR_DIS_FUSES: fuse_index = 2'd2;
      default:        fuse_index = 2'd3;
    endcase
  endfunction

  assign prog_idx = fuse_index(prog_req.addr);

  always_comb begin
    case (prog_idx)
      2'd0:    prog_cur = wp_reg;
      2'd1:    prog_cur = ad_reg;
      2'd2:    prog_cur = dis_reg;
      default: prog_cur = en_reg;
    endcase
  end

  // Checks the ordering of disable and enable fuse programming.
  always_comb begin
    prog_ok = !prog_from_flash && !prot_on &&
              (prog_req.addr == ADDR_WP_FUSES ||
               prog_req.addr == ADDR_AD_FUSES ||
               prog_req.addr == ADDR_DIS_FUSES ||
               prog_req.addr == ADDR_EN_FUSES);
    for (int i = 0; i < NUM_PAIR; i++) begin
      if (prog_idx == 2'd2 && !prog_req.data[i] && dis_reg[i]) begin
        if (i == 0) begin
          if (ad_reg[BIT_ACCESS_PROTECT_FUSE] || ad_reg[BIT_DEBUG_PROTECT_FUSE]) prog_ok = 1'b0;
        end else if (en_reg[i-1]) begin
          prog_ok = 1'b0;
        end
      end
      if (prog_idx == 2'd3 && !prog_req.data[i] && en_reg[i] && dis_reg[i])
        prog_ok = 1'b0;
    end
  end

  // Fuse loading sequence and programming state.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg     <= FPL_ST_LOAD;
      load_idx_reg  <= 2'd0;
      load_wait_reg <= 1'b0;
    end else begin
      case (state_reg)
        FPL_ST_LOAD: begin
          load_wait_reg <= !load_wait_reg;
          if (load_wait_reg) begin
            load_idx_reg <= load_idx_reg + 2'd1;
            if (load_idx_reg == 2'd3) state_reg <= FPL_ST_RUN;
          end
        end
        FPL_ST_RUN: begin
          if (prog_req.valid && prog_ok) state_reg <= FPL_ST_PROG;
        end
        FPL_ST_PROG: state_reg <= FPL_ST_DONE;
        FPL_ST_DONE: state_reg <= FPL_ST_RUN;
        default:     state_reg <= FPL_ST_LOAD;
      endcase
    end
  end

  assign fuse_rd_req = (state_reg == FPL_ST_LOAD) && !load_wait_reg;
  assign fuse_rd_idx = load_idx_reg;

  // Volatile copies: forced active in reset except the disable copy (erased), then loaded and updated.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_reg  <= FUSE_ACTIVE;
      ad_reg  <= FUSE_ACTIVE;
      dis_reg <= FUSE_ERASED;
      en_reg  <= FUSE_ACTIVE;
    end else if (state_reg == FPL_ST_LOAD && load_wait_reg) begin
      case (load_idx_reg)
        2'd0:    wp_reg  <= fuse_rd_data;
        2'd1:    ad_reg  <= fuse_rd_data;
        2'd2:    dis_reg <= fuse_rd_data;
        default: en_reg  <= fuse_rd_data;
      endcase
    end else if (state_reg == FPL_ST_RUN && prog_req.valid && prog_ok) begin
      case (prog_idx)
        2'd0:    wp_reg  <= prog_req.data;
        2'd1:    ad_reg  <= ad_reg & prog_req.data;
        2'd2:    dis_reg <= dis_reg & prog_req.data;
        default: en_reg  <= en_reg & prog_req.data;
      endcase
    end
  end

  // Fuse write: only zeros land in the array; sector ones stay volatile.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fuse_wr      <= 1'b0;
      fuse_wr_idx  <= 2'd0;
      fuse_wr_data <= FUSE_ERASED;
      prog_refused <= 1'b0;
    end else begin
      fuse_wr      <= state_reg == FPL_ST_RUN && prog_req.valid && prog_ok;
      fuse_wr_idx  <= prog_idx;
      fuse_wr_data <= prog_cur & prog_req.data;
      prog_refused <= state_reg == FPL_ST_RUN && prog_req.valid && !prog_ok;
    end
  end

  assign prog_done = (state_reg == FPL_ST_DONE);

  // Temporary unprotect bit.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      temporary_unprotect_bit_reg <= 1'b0;
    end else if (reg_wr && reg_addr == OFS_TAU) begin
      if (!reg_wdata[BIT_TEMPORARY_UNPROTECT_BIT]) temporary_unprotect_bit_reg <= 1'b0;
      else if (reg_wr_from_flash) temporary_unprotect_bit_reg <= 1'b1;
    end
  end

  // Sector write gating and error flag; the set wins over a clear.
  assign sect_allow = sect_req ? (sect_sel & wp_reg[NUM_SECT-1:0]) : 10'h000;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_err_reg <= 1'b0;
    end else if (sect_req && |(sect_sel & ~wp_reg[NUM_SECT-1:0])) begin
      wp_err_reg <= 1'b1;
    end else if (reg_wr && reg_addr == OFS_STATUS && reg_wdata[1]) begin
      wp_err_reg <= 1'b0;
    end
  end
  assign wp_error = wp_err_reg;

  // Data and control access gating.
  always_comb begin
    data_allow = data_acc.valid;
    if (prot_on && data_acc.from_pec) data_allow = 1'b0;
    else if (prot_on && !data_acc.from_flash) data_allow = 1'b0;
    ctrl_allow = ctrl_acc.valid && (!ctrl_acc.write || !prot_on);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_dummy <= 1'b0;
      trap_req   <= 1'b0;
      trap_code  <= DUMMY_DATA;
    end else begin
      data_dummy <= data_acc.valid && !data_acc.write && !data_allow;
      trap_req   <= data_acc.valid && !data_acc.write && !data_allow &&
                    !data_acc.from_pec;
      trap_code  <= TRAP_CODE;
    end
  end

  assign debug_enable     = loaded && ad_reg[BIT_DEBUG_PROTECT_FUSE];
  assign access_protected = prot_on;

  // Register read port, data one cycle after the strobe.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_TAU:     reg_rdata <= {15'h0000, temporary_unprotect_bit_reg};
        OFS_STATUS:  reg_rdata <= {13'h0000, prot_on, wp_err_reg, loaded};
        OFS_WP_VOL:  reg_rdata <= wp_reg;
        OFS_AD_VOL:  reg_rdata <= ad_reg;
        OFS_DIS_VOL: reg_rdata <= dis_reg;
        OFS_EN_VOL:  reg_rdata <= en_reg;
        default:     reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  sequence s_load_done;
    state_reg == FPL_ST_LOAD && load_wait_reg && load_idx_reg == 2'd3;
  endsequence

  a_load_ends_run: assert property (@(posedge clk) disable iff (!rst_n)
    s_load_done |=> state_reg == FPL_ST_RUN)
    else $error("fuse load did not finish");
  a_reset_forces_prot: assert property (@(posedge clk) disable iff (!rst_n)
    !loaded |-> access_protected && !debug_enable)
    else $error("protection not forced before load");
  a_flash_prog_refused: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == FPL_ST_RUN && prog_req.valid && prog_from_flash
    |=> prog_refused && !fuse_wr)
    else $error("programming from flash accepted");
  a_fuse_no_rise: assert property (@(posedge clk) disable iff (!rst_n)
    loaded && $past(loaded) |-> (ad_reg & ~$past(ad_reg)) == 16'h0000)
    else $error("access fuse bit rose");
  a_sector_block: assert property (@(posedge clk) disable iff (!rst_n)
    (sect_allow & ~wp_reg[9:0]) == 10'h000)
    else $error("protected sector allowed");
  a_data_block: assert property (@(posedge clk) disable iff (!rst_n)
    prot_on && data_acc.valid && !data_acc.from_flash |-> !data_allow)
    else $error("protected data access allowed");
  a_temporary_unprotect_bit_flash_only: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(temporary_unprotect_bit_reg) |-> $past(reg_wr_from_flash))
    else $error("unprotect bit set from outside flash");
  a_trap_read: assert property (@(posedge clk) disable iff (!rst_n)
    data_acc.valid && !data_acc.write && !data_acc.from_pec && !data_allow
    |=> trap_req && trap_code == 16'h009b)
    else $error("blocked read did not trap");
  a_ctrl_write_block: assert property (@(posedge clk) disable iff (!rst_n)
    prot_on && ctrl_acc.write |-> !ctrl_allow)
    else $error("control write allowed while protected");
  a_wp_error_set: assert property (@(posedge clk) disable iff (!rst_n)
    sect_req && |(sect_sel & ~wp_reg[9:0]) |=> wp_error)
    else $error("write protection flag not set");

  // Request phases of a protection-programming operation, and the start of the fuse load.
  sequence s_prog_accept;
    state_reg == FPL_ST_RUN && prog_req.valid && prog_ok;
  endsequence

  sequence s_prog_reject;
    state_reg == FPL_ST_RUN && prog_req.valid && !prog_ok;
  endsequence

  sequence s_load_start;
    state_reg == FPL_ST_LOAD && load_idx_reg == 2'd0 && !load_wait_reg;
  endsequence

  // An accepted request writes the fuse, then reports completion.
  a_prog_answer: assert property (@(posedge clk) disable iff (!rst_n)
    s_prog_accept |=> fuse_wr ##1 prog_done)
    else $error("accepted programming did not complete");

  // A refused request never reaches the fuse array.
  a_prog_reject: assert property (@(posedge clk) disable iff (!rst_n)
    s_prog_reject |=> prog_refused && !fuse_wr)
    else $error("refused programming reached the fuses");

  // Loading four words takes eight cycles from the first read.
  a_load_span: assert property (@(posedge clk) disable iff (!rst_n)
    s_load_start |-> ##8 state_reg == FPL_ST_RUN)
    else $error("fuse load took the wrong number of cycles");

  // Disable and enable copies only ever lose ones.
  a_dis_no_rise: assert property (@(posedge clk) disable iff (!rst_n)
    loaded && $past(loaded) |-> (dis_reg & ~$past(dis_reg)) == 16'h0000)
    else $error("disable fuse bit rose");

  a_en_no_rise: assert property (@(posedge clk) disable iff (!rst_n)
    loaded && $past(loaded) |-> (en_reg & ~$past(en_reg)) == 16'h0000)
    else $error("enable fuse bit rose");

  // A programmed debug fuse keeps the test interface shut.
  a_debug_closed: assert property (@(posedge clk) disable iff (!rst_n)
    loaded && !ad_reg[BIT_DEBUG_PROTECT_FUSE] |-> !debug_enable)
    else $error("debug open with debug fuse programmed");

  // The first disable fuse with its enable erased lifts protection.
  a_cancel_pair: assert property (@(posedge clk) disable iff (!rst_n)
    loaded && !dis_reg[0] && en_reg[0] |-> !access_protected)
    else $error("disable pair did not cancel protection");

  // The first disable fuse needs both access and debug fuses set.
  a_dis0_order: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == FPL_ST_RUN && prog_req.valid && prog_ok &&
    prog_idx == 2'd2 && !prog_req.data[0] && dis_reg[0]
    |-> !ad_reg[BIT_ACCESS_PROTECT_FUSE] && !ad_reg[BIT_DEBUG_PROTECT_FUSE])
    else $error("disable fuse programmed out of order");

  // An enable fuse needs its disable fuse already programmed.
  a_en0_order: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == FPL_ST_RUN && prog_req.valid && prog_ok &&
    prog_idx == 2'd3 && !prog_req.data[0] |-> !dis_reg[0])
    else $error("enable fuse programmed out of order");

  // Clearing the unprotect bit always takes effect.
  a_temporary_unprotect_bit_clear: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFS_TAU && !reg_wdata[BIT_TEMPORARY_UNPROTECT_BIT]
    |=> !temporary_unprotect_bit_reg)
    else $error("unprotect bit not cleared");

  // The unprotect bit reads back in the cycle after the strobe.
  a_tau_readback: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFS_TAU
    |=> reg_rdata == {15'h0000, $past(temporary_unprotect_bit_reg)})
    else $error("unprotect bit read back wrong");

  // Event controller transfers stay out while protected.
  a_pec_block: assert property (@(posedge clk) disable iff (!rst_n)
    prot_on && data_acc.valid && data_acc.from_pec |-> !data_allow)
    else $error("event controller transfer allowed");

  // A blocked event controller read gives dummy data but no trap.
  a_pec_no_trap: assert property (@(posedge clk) disable iff (!rst_n)
    data_acc.valid && !data_acc.write && data_acc.from_pec && !data_allow
    |=> data_dummy && !trap_req)
    else $error("event controller read handled wrongly");

  // Sector words go straight into the volatile copy.
  a_wp_copy: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == FPL_ST_RUN && prog_req.valid && prog_ok &&
    prog_idx == 2'd0 |=> wp_reg == $past(prog_req.data))
    else $error("sector copy not updated");
endmodule

//--- testbench/fpl_fuse_model.sv
`timescale 1ns/10ps
module fpl_fuse_model #(
  parameter logic [15:0] INIT_SECT = 16'hffff
) (
  // Clock.
  input  wire logic        clk,
  // Fuse array port.
  input  wire logic        fuse_rd_req,
  input  wire logic [1:0]  fuse_rd_idx,
  output logic      [15:0] fuse_rd_data,
  input  wire logic        fuse_wr,
  input  wire logic [1:0]  fuse_wr_idx,
  input  wire logic [15:0] fuse_wr_data
);
  logic [15:0] mem [4];

  initial begin
    mem[0] = INIT_SECT;
    mem[1] = 16'hffff;
    mem[2] = 16'hffff;
    mem[3] = 16'hffff;
    fuse_rd_data = 16'h0000;
  end

  // Outside an answer the read bus toggles so stale data is never reused.
  always @(posedge clk) begin
    if (fuse_rd_req) begin
      fuse_rd_data <= mem[fuse_rd_idx];
    end else begin
      fuse_rd_data <= ~fuse_rd_data;
    end
  end

  // Cells only ever move from one to zero.
  always @(posedge clk) begin
    if (fuse_wr) begin
      mem[fuse_wr_idx] <= mem[fuse_wr_idx] & fuse_wr_data;
    end
  end
endmodule

//--- testbench/tb_fpl_protect.sv
`timescale 1ns/10ps
module tb_fpl_protect;
  import fpl_pkg::*;
  typedef struct packed {
    fpl_access_type acc;
    logic           ctrl;
    logic           exp;
  } fpl_row_type;
  logic clk, rst_n, fuse_rd_req, fuse_wr, prog_from_flash, prog_done;
  logic prog_refused, sect_req, wp_error, data_allow, data_dummy;
  logic trap_req, ctrl_allow, debug_enable, access_protected;
  logic reg_wr, reg_rd, reg_wr_from_flash;
  logic [1:0] fuse_rd_idx, fuse_wr_idx;
  logic [15:0] fuse_rd_data, fuse_wr_data, trap_code, reg_wdata, reg_rdata;
  logic [15:0] rd;
  logic [9:0] sect_sel, sect_allow;
  logic [7:0] reg_addr;
  fpl_prog_type prog_req;
  fpl_access_type data_acc, ctrl_acc;
  int failures, checked;
  fpl_row_type rows [6] = '{ '{4'b1000, 1'b0, 1'b0}, '{4'b1100, 1'b0, 1'b0},
    '{4'b1010, 1'b0, 1'b1}, '{4'b1001, 1'b0, 1'b0},
    '{4'b1000, 1'b1, 1'b1}, '{4'b1100, 1'b1, 1'b0} };

  fpl_protect u_fpl_protect (.clk(clk), .rst_n(rst_n),
    .fuse_rd_req(fuse_rd_req), .fuse_rd_idx(fuse_rd_idx),
    .fuse_rd_data(fuse_rd_data), .fuse_wr(fuse_wr),
    .fuse_wr_idx(fuse_wr_idx), .fuse_wr_data(fuse_wr_data),
    .prog_req(prog_req), .prog_from_flash(prog_from_flash),
    .prog_done(prog_done), .prog_refused(prog_refused),
    .sect_req(sect_req), .sect_sel(sect_sel), .sect_allow(sect_allow),
    .wp_error(wp_error), .data_acc(data_acc), .data_allow(data_allow),
    .data_dummy(data_dummy), .trap_req(trap_req), .trap_code(trap_code),
    .ctrl_acc(ctrl_acc), .ctrl_allow(ctrl_allow),
    .debug_enable(debug_enable), .access_protected(access_protected),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wr_from_flash(reg_wr_from_flash),
    .reg_rdata(reg_rdata));
  fpl_fuse_model #(.INIT_SECT(16'hfffe)) u_fpl_fuse_model (.clk(clk),
    .fuse_rd_req(fuse_rd_req), .fuse_rd_idx(fuse_rd_idx),
    .fuse_rd_data(fuse_rd_data), .fuse_wr(fuse_wr),
    .fuse_wr_idx(fuse_wr_idx), .fuse_wr_data(fuse_wr_data));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d, input logic f);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr_from_flash <= f; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // Answer arrives as a fuse write then done, or as a refusal.
  task automatic prog(input logic [23:0] a, input logic [15:0] d, input logic f,
                      input logic ok);
    @(posedge clk);
    prog_req <= '{1'b1, a, d}; prog_from_flash <= f;
    @(posedge clk);
    prog_req.valid <= 1'b0;
    #1 chk("fuse_wr", fuse_wr, ok);
    chk("prog_refused", prog_refused, !ok);
    @(posedge clk);
    #1 chk("prog_done", prog_done, ok);
    @(posedge clk);
  endtask
  task automatic sect(input logic [9:0] s, input logic [9:0] e, input logic er);
    @(posedge clk);
    sect_req <= 1'b1; sect_sel <= s;
    @(negedge clk);
    chk("sect_allow", sect_allow, e);
    @(posedge clk);
    sect_req <= 1'b0;
    #1 chk("wp_error", wp_error, er);
  endtask
  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #(50 * 4000);
    failures++;
    summarize();
  end

  initial begin
    rst_n = 1'b0; prog_req = '0; prog_from_flash = 1'b0; sect_req = 1'b0;
    sect_sel = '0; data_acc = '0; ctrl_acc = '0; reg_addr = '0;
    reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0; reg_wr_from_flash = 1'b0;
    failures = 0; checked = 0;
    repeat (8) @(posedge clk);
    chk("prot_in_reset", access_protected, 1'b1);
    chk("dbg_in_reset", debug_enable, 1'b0);
    rst_n <= 1'b1;
    repeat (9) @(posedge clk);
    rreg(OFS_WP_VOL); chk("wp_vol", rd[9:0], 10'h3fe);
    rreg(OFS_AD_VOL); chk("ad_vol", rd, 16'hffff);
    rreg(8'hf0); chk("unmapped", rd, 16'h0000);
    chk("dbg_open", debug_enable, 1'b1);
    prog(ADDR_WP_FUSES, 16'hffff, 1'b1, 1'b0);
    prog(ADDR_DIS_FUSES, 16'hfffe, 1'b0, 1'b0);
    sect(10'h003, 10'h002, 1'b1);
    wreg(OFS_STATUS, 16'h0002, 1'b0);
    rreg(OFS_STATUS); chk("wp_clear", rd[1], 1'b0);
    prog(ADDR_WP_FUSES, 16'hffff, 1'b0, 1'b1);
    chk("fuse_kept", u_fpl_fuse_model.mem[0], 16'hfffe);
    sect(10'h003, 10'h003, 1'b0);
    prog(ADDR_WP_FUSES, 16'hfffe, 1'b0, 1'b1);
    sect(10'h001, 10'h000, 1'b1);
    prog(ADDR_WP_FUSES, 16'hffff, 1'b0, 1'b1);
    wreg(OFS_TAU, 16'h0001, 1'b0);
    rreg(OFS_TAU); chk("tau_ignored", rd[0], 1'b0);
    wreg(OFS_TAU, 16'h0001, 1'b1);
    rreg(OFS_TAU); chk("tau_set", rd[0], 1'b1);
    prog(ADDR_AD_FUSES, 16'hfffc, 1'b0, 1'b1);
    chk("prot_tau", access_protected, 1'b0);
    chk("dbg_closed", debug_enable, 1'b0);
    wreg(OFS_TAU, 16'h0000, 1'b0);
    chk("prot_on", access_protected, 1'b1);
    foreach (rows[i]) begin
      @(posedge clk);
      data_acc <= rows[i].ctrl ? 4'b0000 : rows[i].acc;
      ctrl_acc <= rows[i].ctrl ? rows[i].acc : 4'b0000;
      @(negedge clk);
      if (rows[i].ctrl) chk("ctrl_allow", ctrl_allow, rows[i].exp);
      else chk("data_allow", data_allow, rows[i].exp);
    end
    @(posedge clk);
    data_acc <= 4'b1000; ctrl_acc <= 4'b0000;
    @(posedge clk);
    data_acc <= 4'b0000;
    #1 chk("trap_req", trap_req, 1'b1);
    chk("trap_code", trap_code, TRAP_CODE);
    chk("data_dummy", data_dummy, 1'b1);
    prog(ADDR_WP_FUSES, 16'hffff, 1'b0, 1'b0);
    wreg(OFS_TAU, 16'h0001, 1'b1);
    prog(ADDR_DIS_FUSES, 16'hfffe, 1'b0, 1'b1);
    wreg(OFS_TAU, 16'h0000, 1'b0);
    chk("prot_cancel", access_protected, 1'b0);
    prog(ADDR_DIS_FUSES, 16'hfffd, 1'b0, 1'b0);
    prog(ADDR_EN_FUSES, 16'hfffd, 1'b0, 1'b0);
    prog(ADDR_EN_FUSES, 16'hfffe, 1'b0, 1'b1);
    chk("prot_again", access_protected, 1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (9) @(posedge clk);
    rreg(OFS_WP_VOL); chk("wp_reload", rd[9:0], 10'h3fe);
    rreg(OFS_TAU); chk("tau_reset", rd[0], 1'b0);
    chk("prot_reload", access_protected, 1'b1);
    summarize();
  end
endmodule
